// file: port5_gpio_addr_mux.v
// eight-bit gpio port whose pins may carry address bits a15..a8
`include "port5_map.vh"
// Overview of operation
// - modes 2/4: pin is input or address
// - direction register write-only, reads all ones
// - single-chip: direction one drives latch out
// - reset/hw standby clear direction register
// - software standby keeps direction register
// - modes 2/4: direction one routes address bit
// - modes 1/3: direction forced ones, address out
// - data latch read/write, reset clears it
// - data read: latch for outputs, pins inputs
// - pull-up on when input and latch one
// - pull-ups off in reset, hw standby
// - modes 1/3 pull-ups off; else rule
// - read-modify-write copies input levels into latch
module port5_gpio_addr_mux #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             CLK,
	input  wire             RST,
	// standby and mode controls
	input  wire             HW_STANDBY,
	input  wire             SW_STANDBY,
	input  wire [2:0]       MODE,
	// register port
	input  wire [15:0]      ADDR,
	input  wire [WIDTH-1:0] WDATA,
	input  wire             WR,
	input  wire             RD,
	output wire [WIDTH-1:0] RDATA,
	// external address byte from the bus controller
	input  wire [WIDTH-1:0] BUS_ADDR_HI,
	// pins
	input  wire [WIDTH-1:0] PIN_IN,
	output wire [WIDTH-1:0] PIN_OUT,
	output wire [WIDTH-1:0] PIN_OE,
	output wire [WIDTH-1:0] PULLUP_EN
);
	reg  [WIDTH-1:0] dir_q;      // stored direction bits
	reg  [WIDTH-1:0] dir_d;      // next direction bits
	reg  [WIDTH-1:0] latch_q;    // data latch
	reg  [WIDTH-1:0] latch_d;    // next data latch
	reg  [WIDTH-1:0] rdata_q;    // read data, one cycle after strobe
	reg  [WIDTH-1:0] rdata_d;    // next read data
	reg  [WIDTH-1:0] pin_out_q;  // registered pin drive value
	wire [WIDTH-1:0] pin_level;  // synchronised pin levels
	wire [WIDTH-1:0] dir_eff;    // direction as the pins see it
	wire [WIDTH-1:0] port_view;  // value a data read returns
	wire             full_addr;  // modes 1 and 3
	wire             sel_addr;   // modes 2 and 4
	wire             single_chip; // mode 7 and others
	wire             pu_allowed; // pull-ups usable in this mode
	wire             init;       // reset or hardware standby
	wire             hit_dir;    // direction register selected
	wire             hit_latch;  // data latch selected

	// pins are asynchronous, so two flops before any use
	pin_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk      (CLK),
		.rst      (RST),
		.async_in (PIN_IN),
		.sync_out (pin_level)
	);

	// mode classification, the mode being a static strap
	mode_decode u_mode (
		.mode           (MODE),
		.full_addr      (full_addr),
		.sel_addr       (sel_addr),
		.single_chip    (single_chip),
		.pullup_allowed (pu_allowed)
	);

	assign init      = RST || HW_STANDBY;
	assign hit_dir   = (ADDR == `PIN_DIRECTION_ADDR);
	assign hit_latch = (ADDR == `PIN_DATA_LATCH_ADDR);

	// modes 1 and 3 see all ones whatever is stored
	assign dir_eff = full_addr ? {WIDTH{1'b1}} : dir_q;

	// outputs show the latch, inputs show the live pin
	assign port_view = (dir_eff & latch_q) | (~dir_eff & pin_level);

	// next-state for the direction register
	always @*
	begin
		dir_d = dir_q;
		if (WR && hit_dir && !full_addr)
		begin
			// writes ignored while forced to ones
			dir_d = WDATA;
		end
	end

	// next-state for the data latch
	always @*
	begin
		latch_d = latch_q;
		if (WR && hit_latch)
		begin
			// a read-modify-write brings input levels back in here
			latch_d = WDATA;
		end
	end

	// read path; data stands one cycle after the strobe
	always @*
	begin
		rdata_d = `UNMAPPED_READ_VALUE;
		if (RD && hit_dir)
		begin
			// write-only register, no error, reads as ones
			rdata_d = `DIR_READ_VALUE;
		end
		else if (RD && hit_latch)
		begin
			rdata_d = port_view;
		end
	end

	// register state; software standby is deliberately not a reset
	always @(posedge CLK)
	begin
		if (init)
		begin
			dir_q   <= `PIN_DIRECTION_RST;
			latch_q <= `PIN_DATA_LATCH_RST;
			rdata_q <= `UNMAPPED_READ_VALUE;
		end
		else
		begin
			// settings held through software standby
			dir_q   <= dir_d;
			latch_q <= latch_d;
			rdata_q <= rdata_d;
		end
	end

	// pin drive value: address byte in expanded modes, latch otherwise
	always @(posedge CLK)
	begin
		if (RST)
		begin
			pin_out_q <= {WIDTH{1'b0}};
		end
		else if (single_chip)
		begin
			pin_out_q <= latch_d;
		end
		else
		begin
			// address only leaves where the direction bit allows
			pin_out_q <= BUS_ADDR_HI;
		end
	end

	// output enable per pin
	assign PIN_OE = init ? {WIDTH{1'b0}} :
	                (single_chip ? dir_q : dir_eff);

	assign PIN_OUT = pin_out_q;

	// pull-up: input pin with a one in its latch, outside reset and hardware standby
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_pu
			assign PULLUP_EN[i] = !init && pu_allowed &&
			                      !dir_eff[i] && latch_q[i];
		end
	endgenerate

	assign RDATA = rdata_q;

	// software standby needs no logic here; kept visible for intent
	wire unused_sw_standby = SW_STANDBY;
endmodule

// file: port5_map.vh
// register offsets, reset values and mode codes for the address-byte port
`ifndef PORT5_MAP_VH
`define PORT5_MAP_VH
`define PIN_DIRECTION_ADDR  16'hFF88
`define PIN_DATA_LATCH_ADDR 16'hFF8A
`define PIN_DIRECTION_RST   8'h00
`define PIN_DATA_LATCH_RST  8'h00
`define DIR_READ_VALUE      8'hFF
`define UNMAPPED_READ_VALUE 8'h00
`define MODE_FULL_ADDR_A    3'h1
`define MODE_SEL_ADDR_A     3'h2
`define MODE_FULL_ADDR_B    3'h3
`define MODE_SEL_ADDR_B     3'h4
`define MODE_SINGLE_CHIP    3'h7
`endif

// file: pin_sync.v
// two-stage synchroniser for a bus of pin levels
module pin_sync #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// asynchronous in, synchronous out
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;   // first stage, read only by the second
	reg [WIDTH-1:0] stable_q; // second stage

	// plain two-flop chain, one per bit
	always @(posedge clk)
	begin
		if (rst)
		begin
			meta_q   <= {WIDTH{1'b0}};
			stable_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q   <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;
endmodule

// file: mode_decode.v
// decodes the static operating mode into pin-behaviour classes
`include "port5_map.vh"
module mode_decode (
	// mode strap
	input  wire [2:0] mode,
	// decoded classes
	output wire       full_addr,
	output wire       sel_addr,
	output wire       single_chip,
	output wire       pullup_allowed
);
	// modes 1 and 3 always carry the address byte
	assign full_addr   = (mode == `MODE_FULL_ADDR_A) ||
	                     (mode == `MODE_FULL_ADDR_B);
	// modes 2 and 4 choose per pin
	assign sel_addr    = (mode == `MODE_SEL_ADDR_A) ||
	                     (mode == `MODE_SEL_ADDR_B);
	// anything else behaves as single-chip
	assign single_chip = !full_addr && !sel_addr;
	// pull-ups never usable while the address byte is forced
	assign pullup_allowed = !full_addr;
endmodule

// file: port5_assertions.sv
// assertions on the address-byte port pins and register port
module port5_chk (
	// clock, reset, standby, strobes
	input wire logic        CLK, RST, HW_STANDBY, WR, RD,
	// mode and bus
	input wire logic [2:0]  MODE,
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA, RDATA, BUS_ADDR_HI,
	// pins
	input wire logic [7:0]  PIN_OUT, PIN_OE, PULLUP_EN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// full-address modes force every pin out
	wire full = MODE == 3'h1 || MODE == 3'h3;
	AST_DIR_READ: assert property (RD && ADDR == 16'hFF88 |=> RDATA == 8'hFF)
		else $error("direction read not all ones");
	AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside its slot");
	AST_HW_OFF: assert property (HW_STANDBY |-> PIN_OE == 0 && PULLUP_EN == 0)
		else $error("drive or pull-up in hardware standby");
	AST_FULL_OE: assert property (full && !HW_STANDBY |-> PIN_OE == 8'hFF)
		else $error("full-address pin not driving");
	AST_FULL_PU: assert property (full |-> PULLUP_EN == 8'h00)
		else $error("pull-up on in full-address mode");
	AST_PU_INPUT: assert property ((PULLUP_EN & PIN_OE) == 8'h00)
		else $error("pull-up on a driven pin");
	AST_ADDR_OUT: assert property (MODE inside {[3'h1:3'h4]} && !HW_STANDBY
		|=> PIN_OUT == $past(BUS_ADDR_HI)) else $error("address byte not out");
	AST_LATCH_OUT: assert property (MODE == 3'h7 && WR && ADDR == 16'hFF8A
		&& !HW_STANDBY |=> ((PIN_OUT ^ $past(WDATA)) & PIN_OE) == 8'h00)
		else $error("latch not on output pins");
	// main scenarios reached
	cover property (RD && ADDR == 16'hFF8A);
	cover property (full && WR);
	cover property ($fell(HW_STANDBY));
endmodule
bind port5_gpio_addr_mux port5_chk port5_chk_i (.CLK(CLK), .RST(RST),
	.HW_STANDBY(HW_STANDBY), .WR(WR), .RD(RD), .MODE(MODE), .ADDR(ADDR),
	.WDATA(WDATA), .RDATA(RDATA), .BUS_ADDR_HI(BUS_ADDR_HI),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN));

// file: ext_periph.sv
// peripheral model on the far side of the port pins
module ext_periph (
	// port side
	input wire logic [7:0] PIN_OUT, PIN_OE, PULLUP_EN,
	// peripheral drive level and enable
	input wire logic [7:0] ext_val,
	input wire logic       ext_oe,
	output logic [7:0]     PIN_IN
);
	timeunit 1ns;
	timeprecision 100ps;
	// port drive wins; released pins show peripheral or pull-up level
	assign PIN_IN = PIN_OE & PIN_OUT | ~PIN_OE & (ext_oe ? ext_val : PULLUP_EN);
endmodule

// file: test_port5_gpio_addr_mux.sv
// self-checking bench for the address-byte port
module test_port5_gpio_addr_mux;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 0, RST = 1, HW_STANDBY = 0, SW_STANDBY = 0, WR = 0, RD = 0;
	logic [2:0] MODE = 3'h7;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0] WDATA = 8'h00, BUS_ADDR_HI = 8'h96;
	wire [7:0] RDATA, PIN_IN, PIN_OUT, PIN_OE, PULLUP_EN;
	int failures = 0, checks = 0;
	always #2 CLK = ~CLK;
	port5_gpio_addr_mux port5_gpio_addr_mux_i (.CLK(CLK), .RST(RST),
		.HW_STANDBY(HW_STANDBY), .SW_STANDBY(SW_STANDBY), .MODE(MODE),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.BUS_ADDR_HI(BUS_ADDR_HI), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
		.PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN));
	ext_periph ext_periph_i (.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
		.PULLUP_EN(PULLUP_EN), .ext_val(8'hA5), .ext_oe(1'b1), .PIN_IN(PIN_IN));
	task check(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		WR <= 1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 0;
		@(posedge CLK);
	endtask
	// pin levels need two cycles through the synchroniser first
	task rd(input logic [15:0] a, input string n, input logic [7:0] e);
		repeat (2) @(posedge CLK);
		RD <= 1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 0;
		#1 check(n, RDATA, e);
		@(posedge CLK);
	endtask
	task reset(input logic [2:0] m);
		RST <= 1;
		MODE <= m;
		repeat (8) @(posedge CLK);
		check("oe", PIN_OE, 8'h00);
		check("pullup", PULLUP_EN, 8'h00);
		RST <= 0;
		@(posedge CLK);
	endtask
	// modes 1, 2, 3, 4 and 7: low nibble direction, high nibble latch
	task modes;
		logic [2:0] m [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		logic f;
		foreach (m[i])
		begin
			f = m[i] == 3'h1 || m[i] == 3'h3;
			reset(m[i]);
			wr(16'hFF88, 8'h0F);
			wr(16'hFF8A, 8'hF0);
			check("oe", PIN_OE, f ? 8'hFF : 8'h0F);
			check("pullup", PULLUP_EN, f ? 8'h00 : 8'hF0);
			check("out", PIN_OUT & PIN_OE, m[i] == 3'h7 ? 8'h00 :
				BUS_ADDR_HI & PIN_OE);
			rd(16'hFF8A, "data", f ? 8'hF0 : 8'hA0);
		end
	endtask
	// read-modify-write, standby kinds, write-only and unmapped places
	task single_chip;
		reset(3'h7);
		wr(16'hFF88, 8'hF0);
		wr(16'hFF8A, 8'h3C);
		rd(16'hFF8A, "data", 8'h35);
		wr(16'hFF8A, 8'h35 | 8'h40);
		check("pullup", PULLUP_EN, 8'h05);
		SW_STANDBY <= 1;
		@(posedge CLK);
		check("oe", PIN_OE, 8'hF0);
		check("out", PIN_OUT & PIN_OE, 8'h70);
		HW_STANDBY <= 1;
		@(posedge CLK);
		#1 check("pullup", PULLUP_EN, 8'h00);
		HW_STANDBY <= 0;
		SW_STANDBY <= 0;
		@(posedge CLK);
		rd(16'hFF8A, "data", 8'hA5);
		rd(16'hFF88, "dir", 8'hFF);
		rd(16'hFF8C, "unmapped", 8'h00);
	endtask
	task finish_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		modes;
		single_chip;
		finish_test;
	end
	// watchdog well past the expected run of under a thousand cycles
	initial
	begin
		#20000;
		failures++;
		finish_test;
	end
endmodule
